// ===== rtl/phy_pins_consts.svh
// phy_pins_consts.svh - offsets, field positions, reset values, rates
// assumes: included by bare name from the design files and the bench
`ifndef PHY_PINS_CONSTS_SVH
`define PHY_PINS_CONSTS_SVH

// register byte offsets on the axi4-lite slave
`define REG_CTRL_OFS      8'h00
`define REG_STAT_OFS      8'h04

// control register fields
`define CTRL_TE_BIT       0
`define CTRL_ALT_BIT      1
`define CTRL_TX_CLOCK_OUT_ENABLE_BIT     2
`define CTRL_PCHK_BIT     3
`define CTRL_RST          4'h0

// status register fields
`define STAT_PERR_A_BIT   0
`define STAT_PERR_B_BIT   1
`define STAT_TXE_BIT      2
`define STAT_SD_BIT       3
`define STAT_MODE_LSB     4

// axi response codes
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

// media link rates, printed figures
`define TX_BIT_RATE_MBPS  125
`define TX_CLK_MHZ        125

// indicate path reset: all-zero word with parity one stays odd
`define IND_PAR_RST       1'h1
`define SYM_RST           4'h0

`endif

// ===== rtl/phy_pins_pkg.sv
// phy_pins_pkg.sv - types and parity helper for the phy pin logic
// assumes: compiled before every design file
package phy_pins_pkg;

    // transmit mode field coding, as reported by the transmitter
    typedef enum logic [2:0] {
        off_transmit_mode = 3'b000,
        active_mode       = 3'b001,
        idle_mode         = 3'b010,
        quiet_mode        = 3'b011,
        halt_mode         = 3'b100,
        master_mode       = 3'b101,
        spare6_mode       = 3'b110,
        spare7_mode       = 3'b111
    } tx_mode_t;

    // parity bit that makes flag plus symbols an odd 10-bit word
    function automatic logic odd_fill(input logic ctrl, input logic [7:0] sym);
        return ~^{ctrl, sym};
    endfunction : odd_fill

    // true when the whole 10-bit word has odd parity
    function automatic logic word_odd(input logic par, input logic ctrl,
                                      input logic [7:0] sym);
        return ^{par, ctrl, sym};
    endfunction : word_odd

endpackage : phy_pins_pkg

// ===== rtl/phy_port_path.sv
// phy_port_path.sv - one phy port: indicate packing, request checking
// assumes: inputs synchronous to clk_sys, request side driven by the mac
`timescale 1ns/1ns
`include "phy_pins_consts.svh"
module phy_port_path (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       chk_en,
    input  wire logic       ind_is_ctrl,
    input  wire logic [3:0] ind_first,
    input  wire logic [3:0] ind_second,
    input  wire logic       req_parity,
    input  wire logic       req_ctrl_flag,
    input  wire logic [7:0] req_symbols,
    output logic            ind_parity,
    output logic            ind_ctrl_flag,
    output logic [7:0]      ind_symbols,
    output logic            req_is_ctrl,
    output logic [3:0]      req_first,
    output logic [3:0]      req_second,
    output logic            par_err
);

    //////////////////////////////////////////////////////////////////
    // indicate side

    wire logic [7:0] ind_word = {ind_first, ind_second};
    wire logic       ind_par  = phy_pins_pkg::odd_fill(ind_is_ctrl, ind_word);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ind_parity    <= `IND_PAR_RST;
            ind_ctrl_flag <= 1'b0;
            ind_symbols   <= {`SYM_RST, `SYM_RST};
        end else begin
            ind_parity    <= ind_par;
            ind_ctrl_flag <= ind_is_ctrl;
            ind_symbols   <= ind_word;
        end
    end

    //////////////////////////////////////////////////////////////////
    // request side

    wire logic req_bad = chk_en &
                         ~phy_pins_pkg::word_odd(req_parity, req_ctrl_flag, req_symbols);

    // request word handed on, error flag one cycle after each bad word while chk_en is set
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            req_is_ctrl <= 1'b0;
            req_first   <= `SYM_RST;
            req_second  <= `SYM_RST;
            par_err     <= 1'b0;
        end else begin
            req_is_ctrl <= req_ctrl_flag;
            req_first   <= req_symbols[7:4];
            req_second  <= req_symbols[3:0];
            par_err     <= req_bad;
        end
    end

    //////////////////////////////////////////////////////////////////
    // checks

    property p_ind_odd;
        @(posedge clk_sys) disable iff (!rst_n)
        1'b1 |=> (^{ind_parity, ind_ctrl_flag, ind_symbols}) == 1'b1;
    endproperty
    a_ind_odd: assert property (p_ind_odd)
        else $error("indicate word not odd parity");

    property p_ind_ctrl;
        @(posedge clk_sys) disable iff (!rst_n)
        ind_is_ctrl |=> ind_ctrl_flag ##1 (ind_ctrl_flag == $past(ind_is_ctrl));
    endproperty
    a_ind_ctrl: assert property (p_ind_ctrl)
        else $error("indicate control flag wrong");

    property p_ind_order;
        @(posedge clk_sys) disable iff (!rst_n)
        1'b1 |=> ind_symbols[7:4] == $past(ind_first)
              && ind_symbols[3:0] == $past(ind_second);
    endproperty
    a_ind_order: assert property (p_ind_order)
        else $error("indicate symbol order wrong");

    property p_req_err;
        @(posedge clk_sys) disable iff (!rst_n)
        (chk_en && !(^{req_parity, req_ctrl_flag, req_symbols})) |=> par_err;
    endproperty
    a_req_err: assert property (p_req_err)
        else $error("request parity error missed");

endmodule : phy_port_path

// ===== rtl/phy_pins_top.sv
// phy_pins_top.sv - pin logic of the phy port and media interface
// holds: axi4-lite slave, transmitter enable decode, alternate receive
// gating, transmit clock gating, two phy port paths (a and b)
// assumes: every input synchronous to clk_sys; the receive and transmit
// cores supply indicate symbols, transmit mode and serial bits
`timescale 1ns/1ns
`include "phy_pins_consts.svh"
module phy_pins_top (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // axi4-lite slave
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // media transmit side
    input  wire logic [2:0]  tx_mode_field,
    input  wire logic        tx_enable_level_sel,
    output logic             media_tx_enable_out,
    input  wire logic        tx_serial_in,
    input  wire logic        tx_clock_in,
    output logic             media_serial_tx_data,
    output logic             tx_clock_out,
    // media receive side
    input  wire logic        signal_present_in,
    input  wire logic        alt_rx_clock_in,
    input  wire logic        alt_rx_data_in,
    output logic             alt_rx_clock_gated,
    output logic             alt_rx_data_gated,
    // port a, mac side
    input  wire logic        port_a_req_parity,
    input  wire logic        port_a_req_ctrl_flag,
    input  wire logic [7:0]  port_a_req_symbols,
    output logic             port_a_ind_parity,
    output logic             port_a_ind_ctrl_flag,
    output logic [7:0]       port_a_ind_symbols,
    // port a, core side
    input  wire logic        a_ind_is_ctrl,
    input  wire logic [3:0]  a_ind_first,
    input  wire logic [3:0]  a_ind_second,
    output logic             a_req_is_ctrl,
    output logic [3:0]       a_req_first,
    output logic [3:0]       a_req_second,
    // port b, mac side
    input  wire logic        port_b_req_parity,
    input  wire logic        port_b_req_ctrl_flag,
    input  wire logic [7:0]  port_b_req_symbols,
    output logic             port_b_ind_parity,
    output logic             port_b_ind_ctrl_flag,
    output logic [7:0]       port_b_ind_symbols,
    // port b, core side
    input  wire logic        b_ind_is_ctrl,
    input  wire logic [3:0]  b_ind_first,
    input  wire logic [3:0]  b_ind_second,
    output logic             b_req_is_ctrl,
    output logic [3:0]       b_req_first,
    output logic [3:0]       b_req_second
);

    //////////////////////////////////////////////////////////////////
    // bus slave state

    logic        awready_q;    // write address slot free
    logic        wready_q;     // write data slot free
    logic        aw_have_q;    // write address held
    logic        w_have_q;     // write data held
    logic [7:0]  aw_addr_q;    // held write address
    logic [31:0] w_data_q;     // held write data
    logic [3:0]  w_strb_q;     // held byte strobes
    logic        bvalid_q;     // write answer pending
    logic [1:0]  bresp_q;      // write answer code
    logic        arready_q;    // read slot free
    logic        rvalid_q;     // read answer pending
    logic [31:0] rdata_q;      // read answer data
    logic [1:0]  rresp_q;      // read answer code

    // control and status
    logic [3:0]  ctrl_q;       // te, alt, tx_clock_out_enable, parity check
    logic        perr_a_q;     // sticky port a parity error
    logic        perr_b_q;     // sticky port b parity error
    logic        txe_q;        // transmitter enable pin
    logic        ser_q;        // serial data pin
    logic        txc_q;        // transmit clock pin
    logic        alt_clk_q;    // gated alternate clock
    logic        alt_dat_q;    // gated alternate data

    // pulses from the port paths
    wire logic   par_err_a;
    wire logic   par_err_b;

    //////////////////////////////////////////////////////////////////
    // bus decode

    wire logic aw_take = awvalid & awready_q;
    wire logic w_take  = wvalid & wready_q;
    wire logic wr_fire = aw_have_q & w_have_q & ~bvalid_q;
    wire logic wr_ctrl_hit = aw_addr_q == `REG_CTRL_OFS;
    wire logic wr_stat_hit = aw_addr_q == `REG_STAT_OFS;
    wire logic wr_lane0 = wr_fire & w_strb_q[0];
    wire logic wr_ctrl = wr_lane0 & wr_ctrl_hit;
    wire logic wr_stat = wr_lane0 & wr_stat_hit;
    wire logic [1:0] wr_resp = (wr_ctrl_hit | wr_stat_hit) ? `RESP_OKAY
                                                          : `RESP_SLVERR;
    wire logic ar_take = arvalid & arready_q;
    wire logic rd_ctrl_hit = araddr == `REG_CTRL_OFS;
    wire logic rd_stat_hit = araddr == `REG_STAT_OFS;

    // status word as software sees it
    wire logic [31:0] stat_word = {25'h0000000, tx_mode_field,
                                   signal_present_in, txe_q,
                                   perr_b_q, perr_a_q};
    wire logic [31:0] rd_word = rd_ctrl_hit ? {28'h0000000, ctrl_q} :
                                rd_stat_hit ? stat_word : 32'h00000000;
    wire logic [1:0]  rd_resp = (rd_ctrl_hit | rd_stat_hit) ? `RESP_OKAY
                                                           : `RESP_SLVERR;

    //////////////////////////////////////////////////////////////////
    // write channels: address and data taken in either order

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            awready_q <= 1'b1;
            aw_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (aw_take) begin
            awready_q <= 1'b0;
            aw_have_q <= 1'b1;
            aw_addr_q <= awaddr;
        end else if (bvalid_q && bready) begin
            // slot reopens once the answer is taken
            awready_q <= 1'b1;
            aw_have_q <= 1'b0;
        end
    end

    // write data slot
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wready_q <= 1'b1;
            w_have_q <= 1'b0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
        end else if (w_take) begin
            wready_q <= 1'b0;
            w_have_q <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
        end else if (bvalid_q && bready) begin
            wready_q <= 1'b1;
            w_have_q <= 1'b0;
        end
    end

    // write answer, one cycle after both halves are held
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_resp;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////
    // read channel: answer the cycle after the address is taken

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h00000000;
            rresp_q   <= `RESP_OKAY;
        end else if (ar_take) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_word;
            rresp_q   <= rd_resp;
        end else if (rvalid_q && rready) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////
    // control register; all enables clear on reset

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_q <= `CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= w_data_q[3:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            perr_a_q <= 1'b0;
            perr_b_q <= 1'b0;
        end else begin
            perr_a_q <= par_err_a | (perr_a_q & ~(wr_stat & w_data_q[`STAT_PERR_A_BIT]));
            perr_b_q <= par_err_b | (perr_b_q & ~(wr_stat & w_data_q[`STAT_PERR_B_BIT]));
        end
    end

    //////////////////////////////////////////////////////////////////
    // transmitter enable decode

    wire logic te_bit   = ctrl_q[`CTRL_TE_BIT];
    wire logic mode_off = phy_pins_pkg::tx_mode_t'(tx_mode_field)
                          == phy_pins_pkg::off_transmit_mode;
    wire logic tx_live  = te_bit & ~mode_off;
    wire logic txe_d    = tx_live ? tx_enable_level_sel : ~tx_enable_level_sel;

    // enable pin register
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            txe_q <= 1'b0;
        end else begin
            txe_q <= txe_d;
        end
    end

    //////////////////////////////////////////////////////////////////
    // serial transmit and its clock

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ser_q <= 1'b0;
            txc_q <= 1'b0;
        end else begin
            ser_q <= tx_serial_in;
            txc_q <= tx_clock_in & ctrl_q[`CTRL_TX_CLOCK_OUT_ENABLE_BIT];
        end
    end

    //////////////////////////////////////////////////////////////////
    // alternate receive gating

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            alt_clk_q <= 1'b0;
            alt_dat_q <= 1'b0;
        end else begin
            alt_clk_q <= alt_rx_clock_in & ctrl_q[`CTRL_ALT_BIT];
            alt_dat_q <= alt_rx_data_in & ctrl_q[`CTRL_ALT_BIT];
        end
    end

    //////////////////////////////////////////////////////////////////
    // phy ports

    phy_port_path u_port_a (
        .clk_sys       (clk_sys),
        .rst_n         (rst_n),
        .chk_en        (ctrl_q[`CTRL_PCHK_BIT]),
        .ind_is_ctrl   (a_ind_is_ctrl),
        .ind_first     (a_ind_first),
        .ind_second    (a_ind_second),
        .req_parity    (port_a_req_parity),
        .req_ctrl_flag (port_a_req_ctrl_flag),
        .req_symbols   (port_a_req_symbols),
        .ind_parity    (port_a_ind_parity),
        .ind_ctrl_flag (port_a_ind_ctrl_flag),
        .ind_symbols   (port_a_ind_symbols),
        .req_is_ctrl   (a_req_is_ctrl),
        .req_first     (a_req_first),
        .req_second    (a_req_second),
        .par_err       (par_err_a)
    );

    phy_port_path u_port_b (
        .clk_sys       (clk_sys),
        .rst_n         (rst_n),
        .chk_en        (ctrl_q[`CTRL_PCHK_BIT]),
        .ind_is_ctrl   (b_ind_is_ctrl),
        .ind_first     (b_ind_first),
        .ind_second    (b_ind_second),
        .req_parity    (port_b_req_parity),
        .req_ctrl_flag (port_b_req_ctrl_flag),
        .req_symbols   (port_b_req_symbols),
        .ind_parity    (port_b_ind_parity),
        .ind_ctrl_flag (port_b_ind_ctrl_flag),
        .ind_symbols   (port_b_ind_symbols),
        .req_is_ctrl   (b_req_is_ctrl),
        .req_first     (b_req_first),
        .req_second    (b_req_second),
        .par_err       (par_err_b)
    );

    //////////////////////////////////////////////////////////////////
    // outputs straight from flops

    assign awready              = awready_q;
    assign wready               = wready_q;
    assign bvalid               = bvalid_q;
    assign bresp                = bresp_q;
    assign arready              = arready_q;
    assign rvalid               = rvalid_q;
    assign rdata                = rdata_q;
    assign rresp                = rresp_q;
    assign media_tx_enable_out  = txe_q;
    assign media_serial_tx_data = ser_q;
    assign tx_clock_out         = txc_q;
    assign alt_rx_clock_gated   = alt_clk_q;
    assign alt_rx_data_gated    = alt_dat_q;

    //////////////////////////////////////////////////////////////////
    // checks

    property p_txe_live;
        @(posedge clk_sys) disable iff (!rst_n)
        (te_bit && !mode_off) |=> media_tx_enable_out == $past(tx_enable_level_sel);
    endproperty
    a_txe_live: assert property (p_txe_live)
        else $error("enable out not following level");

    property p_txe_idle;
        @(posedge clk_sys) disable iff (!rst_n)
        (!te_bit || mode_off) |=> media_tx_enable_out != $past(tx_enable_level_sel);
    endproperty
    a_txe_idle: assert property (p_txe_idle)
        else $error("enable out not inverted");

    property p_alt_gate;
        @(posedge clk_sys) disable iff (!rst_n)
        !ctrl_q[`CTRL_ALT_BIT] |=> !alt_rx_clock_gated && !alt_rx_data_gated;
    endproperty
    a_alt_gate: assert property (p_alt_gate)
        else $error("alternate input leaked while off");

    property p_txc_gate;
        @(posedge clk_sys) disable iff (!rst_n)
        (ctrl_q[`CTRL_TX_CLOCK_OUT_ENABLE_BIT] && tx_clock_in) |=> tx_clock_out;
    endproperty
    a_txc_gate: assert property (p_txc_gate)
        else $error("transmit clock not passed");

    property p_txc_off;
        @(posedge clk_sys) disable iff (!rst_n)
        !ctrl_q[`CTRL_TX_CLOCK_OUT_ENABLE_BIT] |=> !tx_clock_out;
    endproperty
    a_txc_off: assert property (p_txc_off)
        else $error("transmit clock leaked while off");

    property p_perr_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        par_err_a |=> perr_a_q;
    endproperty
    a_perr_hold: assert property (p_perr_hold)
        else $error("port a parity error lost");

endmodule : phy_pins_top

// ===== tb/mac_partner.sv
// mac_partner.sv - mac side model driving one request path
// assumes: inputs change just after a rising clk_sys edge
`timescale 1ns/1ns
module mac_partner (
    input  wire logic       is_ctrl,
    input  wire logic [3:0] first,
    input  wire logic [3:0] second,
    input  wire logic       spoil,
    output logic            req_parity,
    output logic            req_ctrl_flag,
    output logic [7:0]      req_symbols
);
    assign req_symbols   = {first, second};
    assign req_ctrl_flag = is_ctrl;
    assign req_parity    = ~^{is_ctrl, first, second} ^ spoil;
endmodule : mac_partner

// ===== tb/tb_phy_pins_top.sv
// tb_phy_pins_top.sv - self-checking bench for the phy pin logic
// assumes: rtl package, header and modules compiled first
`timescale 1ns/1ns
`include "phy_pins_consts.svh"
module tb_phy_pins_top;
    logic clk_sys = 1'b0, rst_n = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [2:0] tx_mode_field = 3'h0;
    logic tx_enable_level_sel = 1'b0, tx_serial_in = 1'b0, tx_clock_in = 1'b1;
    logic signal_present_in = 1'b1, alt_rx_clock_in = 1'b1, alt_rx_data_in = 1'b1;
    logic media_tx_enable_out, media_serial_tx_data, tx_clock_out;
    logic alt_rx_clock_gated, alt_rx_data_gated;
    logic port_a_req_parity, port_a_req_ctrl_flag, port_b_req_parity, port_b_req_ctrl_flag;
    logic [7:0] port_a_req_symbols, port_b_req_symbols, port_a_ind_symbols, port_b_ind_symbols;
    logic port_a_ind_parity, port_a_ind_ctrl_flag, port_b_ind_parity, port_b_ind_ctrl_flag;
    logic a_ind_is_ctrl = 1'b0, b_ind_is_ctrl = 1'b0, a_req_is_ctrl, b_req_is_ctrl;
    logic [3:0] a_ind_first = 4'h0, a_ind_second = 4'h0, b_ind_first = 4'h0;
    logic [3:0] b_ind_second = 4'h0, a_req_first, a_req_second, b_req_first, b_req_second;
    logic [9:0] mac_a = 10'h000, mac_b = 10'h000;   // spoil, ctrl, symbols
    // rows: te, mode[2:0], level, expected enable out
    logic [5:0] rows [8] = '{6'h01, 6'h16, 6'h21, 6'h22, 6'h24, 6'h27, 6'h33, 6'h3C};
    int num_errors = 0, compares = 0;

    ////////////////////////////////////////////////////////////////////////////////
    phy_pins_top phy_pins_top_inst (.*);
    mac_partner mac_partner_a_inst (.is_ctrl(mac_a[8]), .first(mac_a[7:4]),
        .second(mac_a[3:0]), .spoil(mac_a[9]), .req_parity(port_a_req_parity),
        .req_ctrl_flag(port_a_req_ctrl_flag), .req_symbols(port_a_req_symbols));
    mac_partner mac_partner_b_inst (.is_ctrl(mac_b[8]), .first(mac_b[7:4]),
        .second(mac_b[3:0]), .spoil(mac_b[9]), .req_parity(port_b_req_parity),
        .req_ctrl_flag(port_b_req_ctrl_flag), .req_symbols(port_b_req_symbols));
    always #50 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("FAIL %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // lets a pin change pass through its output register
    task automatic settle;
        repeat (2) @(negedge clk_sys);
    endtask : settle
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_sys);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (n == 20) begin
            num_errors++;
            final_report();
        end
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_sys);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (n == 20) begin
            num_errors++;
            final_report();
        end
    endtask : axi_rd

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        axi_rd(`REG_CTRL_OFS, d, r);
        chk("ctrl_rst", 32'h0, d);
        chk("gated_rst", 3'h0, {alt_rx_clock_gated, alt_rx_data_gated, tx_clock_out});
        // transmitter enable table
        for (int i = 0; i < 8; i++) begin
            axi_wr(`REG_CTRL_OFS, {31'h0, rows[i][5]});
            tx_mode_field <= rows[i][4:2];
            tx_enable_level_sel <= rows[i][1];
            settle();
            chk("txe", rows[i][0], media_tx_enable_out);
        end
        // alt enable, clock enable, parity check on
        axi_wr(`REG_CTRL_OFS, 32'h0000000E);
        tx_serial_in <= 1'b1;
        a_ind_is_ctrl <= 1'b1;
        a_ind_first <= 4'hA;
        a_ind_second <= 4'h5;
        b_ind_first <= 4'h3;
        b_ind_second <= 4'hC;
        mac_a <= 10'h269;
        mac_b <= 10'h11E;
        settle();
        chk("alt", 2'h3, {alt_rx_clock_gated, alt_rx_data_gated});
        chk("txc", 1'b1, tx_clock_out);
        chk("ser", 1'b1, media_serial_tx_data);
        chk("ind_a", {~^{9'h1A5}, 9'h1A5}, {port_a_ind_parity, port_a_ind_ctrl_flag,
            port_a_ind_symbols});
        chk("ind_b", {~^{9'h03C}, 9'h03C}, {port_b_ind_parity, port_b_ind_ctrl_flag,
            port_b_ind_symbols});
        chk("req_a", 9'h069, {a_req_is_ctrl, a_req_first, a_req_second});
        chk("req_b", 9'h11E, {b_req_is_ctrl, b_req_first, b_req_second});
        @(posedge clk_sys);
        mac_a <= 10'h069;
        axi_rd(`REG_STAT_OFS, d, r);
        chk("stat", 7'h7D, d[6:0]);
        axi_wr(`REG_STAT_OFS, 32'h00000001);
        axi_rd(`REG_STAT_OFS, d, r);
        chk("stat_clr", 2'h0, d[1:0]);
        // check off: spoiled word not flagged
        axi_wr(`REG_CTRL_OFS, 32'h00000006);
        mac_a <= 10'h269;
        settle();
        axi_rd(`REG_STAT_OFS, d, r);
        chk("stat_off", 2'h0, d[1:0]);
        axi_rd(8'h08, d, r);
        chk("rresp", `RESP_SLVERR, r);
        chk("rdata", 32'h0, d);
        chk("bresp_ok", `RESP_OKAY, bresp);
        axi_wr(8'h08, 32'h00000001);
        chk("bresp_bad", `RESP_SLVERR, bresp);
        final_report();
    end
endmodule : tb_phy_pins_top
